// >>> design/ccd_pkg.sv
// Package for the two-channel output clock divider block.
// Holds register indices, field positions, reset values and shared types.
// Assumes a 32-bit classic Wishbone register bus with one word per register.

package ccd_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] CCD_IDX_DIV0_COUNTS = 10'h190;
    localparam logic [9:0] CCD_IDX_DIV0_CTRL = 10'h191;
    localparam logic [9:0] CCD_IDX_DIV0_ROUTE = 10'h192;
    localparam logic [9:0] CCD_IDX_DIV1_COUNTS = 10'h196;
    localparam logic [9:0] CCD_IDX_DIV1_CTRL = 10'h197;
    localparam logic [9:0] CCD_IDX_DIV1_ROUTE = 10'h198;
    localparam logic [9:0] CCD_IDX_STATUS = 10'h19F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CCD_CNT_LOW_LSB = 4;
    localparam int CCD_CNT_HIGH_LSB = 0;
    localparam int CCD_CTRL_BYPASS = 7;
    localparam int CCD_CTRL_NOSYNC = 6;
    localparam int CCD_CTRL_FORCE = 5;
    localparam int CCD_CTRL_START = 4;
    localparam int CCD_CTRL_PHASE_LSB = 0;
    localparam int CCD_ROUTE_DIRECT = 1;
    localparam int CCD_ROUTE_DCC_OFF = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CCD_RST_COUNTS = 8'h00;
    localparam logic [7:0] CCD_RST_CTRL0 = 8'h80;
    localparam logic [7:0] CCD_RST_CTRL1 = 8'h00;
    localparam logic [7:0] CCD_RST_ROUTE = 8'h00;

    // ------------------------------------------------------------------
    // Distribution source select encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CCD_SRC_EXT = 2'h0;
    localparam logic [1:0] CCD_SRC_NONE = 2'h1;
    localparam logic [1:0] CCD_SRC_OSC = 2'h2;

    // Counting state of one divider.
    typedef enum logic [1:0] {
        CCD_ST_HOLD = 2'b00,
        CCD_ST_PHASE = 2'b01,
        CCD_ST_RUN = 2'b11
    } ccd_state_t;

    // Decoded settings of one divider.
    typedef struct packed {
        logic [3:0] low;
        logic [3:0] high;
        logic bypass;
        logic nosync;
        logic force_high;
        logic start_high;
        logic [3:0] phase;
        logic direct;
        logic dcc_off;
    } ccd_cfg_t;

endpackage : ccd_pkg

// >>> design/ccd_channel_clock_divider.sv
// Two programmable channel clock dividers with a Wishbone register file.
// Assumes the distribution clock, oscillator and external clock arrive as
// asynchronous levels sampled on clk_i; one divider input cycle is one
// rising edge of the sampled distribution clock.

`timescale 1ns/1ns
`default_nettype none

// Function
// - Output stays low for low-count field plus one input cycles.
// - Output stays high for high-count field plus one input cycles.
// - Bypass stops counting and passes the input clock to the output.
// - After reset divider one is bypassed, divider two divides.
// - Sync-ignore clear obeys chip sync; set ignores it.
// - Force bit sets the held level; software must also set sync-ignore.
// - Start-level bit picks the level at which division starts.
// - Four-bit phase offset, reset zero, delays the first edge.
// - Direct bit clear: each divider drives its own output pair.
// - Direct bit set: oscillator on select 10b, external clock on 00b.
// - Duty correction applies while its disable bit is clear.
module ccd_channel_clock_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock sources and chip-level controls
    input wire logic internal_oscillator_i,
    input wire logic ext_clk_i,
    input wire logic [1:0] distribution_source_select_i,
    input wire logic sync_i,
    // Output pairs
    output logic first_pair_output_a_o,
    output logic first_pair_output_b_o,
    output logic second_pair_output_a_o,
    output logic second_pair_output_b_o
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Unpacks the three registers of one divider into its settings.
    // Field positions come from the package, so a register map change
    // touches only the package and never this decoding.
    function automatic ccd_pkg::ccd_cfg_t unpack_cfg(
        input logic [7:0] counts,
        input logic [7:0] ctrl,
        input logic [7:0] route
    );
        ccd_pkg::ccd_cfg_t c;
        c.low = counts[ccd_pkg::CCD_CNT_LOW_LSB +: 4];
        c.high = counts[ccd_pkg::CCD_CNT_HIGH_LSB +: 4];
        c.bypass = ctrl[ccd_pkg::CCD_CTRL_BYPASS];
        c.nosync = ctrl[ccd_pkg::CCD_CTRL_NOSYNC];
        c.force_high = ctrl[ccd_pkg::CCD_CTRL_FORCE];
        c.start_high = ctrl[ccd_pkg::CCD_CTRL_START];
        c.phase = ctrl[ccd_pkg::CCD_CTRL_PHASE_LSB +: 4];
        c.direct = route[ccd_pkg::CCD_ROUTE_DIRECT];
        c.dcc_off = route[ccd_pkg::CCD_ROUTE_DCC_OFF];
        return c;
    endfunction : unpack_cfg

    // Picks the level driven onto one output pair before duty correction.
    // Later steps override earlier ones: bypass beats the divider, a
    // forced level beats bypass, and direct routing beats everything.
    // Direct routing with select 01b leaves the earlier choice in place.
    function automatic logic pick_level(
        input ccd_pkg::ccd_cfg_t c,
        input logic div_level,
        input logic dist_level,
        input logic osc_level,
        input logic ext_level,
        input logic [1:0] src,
        input logic sync_on
    );
        logic lvl;
        lvl = div_level;
        if (c.bypass) begin
            lvl = dist_level;
        end
        if (c.nosync && sync_on) begin
            lvl = c.force_high;
        end
        if (c.direct && src == ccd_pkg::CCD_SRC_OSC) begin
            lvl = osc_level;
        end else if (c.direct && src == ccd_pkg::CCD_SRC_EXT) begin
            lvl = ext_level;
        end
        // select 01b falls through to the level picked above.
        return lvl;
    endfunction : pick_level

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Configuration bytes, one set per divider, indexed by divider number.
    // Only the low byte lane of each bus word is stored.
    logic [7:0] counts_r [2];
    logic [7:0] ctrl_r [2];
    logic [7:0] route_r [2];
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] osc_sync_r;
    logic [1:0] ext_sync_r;
    logic [1:0] sync_sync_r;
    logic dist_prev_r;
    ccd_pkg::ccd_state_t state_r [2];
    logic [3:0] cnt_r [2];
    logic [3:0] phase_cnt_r [2];
    logic level_r [2];
    logic out_r [2];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------

    // Word index, request and write strobe for the low byte lane.
    // A request is taken only while no acknowledge is out, so a strobe
    // held across the acknowledge cycle never counts twice.
    wire logic [9:0] word_idx = adr_i[11:2];
    wire logic req = cyc_i && stb_i && !ack_r;
    wire logic wr_lane0 = req && we_i && sel_i[0];
    wire logic hit_c0 = word_idx == ccd_pkg::CCD_IDX_DIV0_COUNTS;
    wire logic hit_k0 = word_idx == ccd_pkg::CCD_IDX_DIV0_CTRL;
    wire logic hit_r0 = word_idx == ccd_pkg::CCD_IDX_DIV0_ROUTE;
    wire logic hit_c1 = word_idx == ccd_pkg::CCD_IDX_DIV1_COUNTS;
    wire logic hit_k1 = word_idx == ccd_pkg::CCD_IDX_DIV1_CTRL;
    wire logic hit_r1 = word_idx == ccd_pkg::CCD_IDX_DIV1_ROUTE;
    wire logic hit_st = word_idx == ccd_pkg::CCD_IDX_STATUS;

    // Read multiplexer; unmapped words read as zero.
    // The status word is read-only and shows levels and run state of
    // both dividers, which helps software see a divider stalled by sync.
    wire logic [7:0] status_byte = {2'h0, state_r[1] == ccd_pkg::CCD_ST_RUN,
                                    state_r[0] == ccd_pkg::CCD_ST_RUN,
                                    out_r[1], out_r[0], level_r[1], level_r[0]};
    wire logic [7:0] rd_byte = hit_c0 ? counts_r[0] :
                               hit_k0 ? ctrl_r[0] :
                               hit_r0 ? route_r[0] :
                               hit_c1 ? counts_r[1] :
                               hit_k1 ? ctrl_r[1] :
                               hit_r1 ? route_r[1] :
                               hit_st ? status_byte : 8'h00;

    // Handshake: ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            rdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdata_r;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Software writes land on the low byte lane of each mapped word.
    // A write without the low byte enable, or to an unmapped word, is
    // acknowledged but changes nothing, so the bus never hangs on it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counts_r[0] <= ccd_pkg::CCD_RST_COUNTS;
            counts_r[1] <= ccd_pkg::CCD_RST_COUNTS;
            ctrl_r[0] <= ccd_pkg::CCD_RST_CTRL0;
            ctrl_r[1] <= ccd_pkg::CCD_RST_CTRL1;
            route_r[0] <= ccd_pkg::CCD_RST_ROUTE;
            route_r[1] <= ccd_pkg::CCD_RST_ROUTE;
        end else begin
            if (wr_lane0 && hit_c0) counts_r[0] <= dat_i[7:0];
            if (wr_lane0 && hit_k0) ctrl_r[0] <= dat_i[7:0];
            if (wr_lane0 && hit_r0) route_r[0] <= dat_i[7:0];
            if (wr_lane0 && hit_c1) counts_r[1] <= dat_i[7:0];
            if (wr_lane0 && hit_k1) ctrl_r[1] <= dat_i[7:0];
            if (wr_lane0 && hit_r1) route_r[1] <= dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------

    // Distribution clock: oscillator on select 10b, otherwise external.
    // The select is a same-clock level, so it is used without retiming.
    // Each source is read only from its second synchroniser stage; the
    // edge detector compares that level with its own registered copy.
    wire logic osc_level = osc_sync_r[1];
    wire logic ext_level = ext_sync_r[1];
    wire logic sync_on = sync_sync_r[1];
    wire logic dist_level = (distribution_source_select_i == ccd_pkg::CCD_SRC_OSC) ?
                            osc_level : ext_level;
    wire logic dist_rise = dist_level && !dist_prev_r;

    // Two stages per asynchronous pin guard against metastability.
    // The previous distribution level resets low, the idle level of the
    // source pins, so no false edge follows reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_sync_r <= 2'h0;
            ext_sync_r <= 2'h0;
            sync_sync_r <= 2'h0;
            dist_prev_r <= 1'b0;
        end else begin
            osc_sync_r <= {osc_sync_r[0], internal_oscillator_i};
            ext_sync_r <= {ext_sync_r[0], ext_clk_i};
            sync_sync_r <= {sync_sync_r[0], sync_i};
            dist_prev_r <= dist_level;
        end
    end

    // ------------------------------------------------------------------
    // Divider channels
    // ------------------------------------------------------------------
    // Both dividers share one distribution clock edge and differ only in
    // their settings. A divider input cycle is one rising edge of the
    // synchronised distribution level, so the source must stay well
    // below half the system clock rate.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_div
            wire ccd_pkg::ccd_cfg_t cfg = unpack_cfg(counts_r[gi], ctrl_r[gi],
                                                     route_r[gi]);
            wire logic hold = sync_on && !cfg.nosync;
            wire logic low_done = cnt_r[gi] == cfg.low;
            wire logic high_done = cnt_r[gi] == cfg.high;
            wire logic span_done = level_r[gi] ? high_done : low_done;
            wire logic raw = pick_level(cfg, level_r[gi], dist_level, osc_level,
                                        ext_level, distribution_source_select_i,
                                        sync_on);

            // Counter advances once per divider input cycle.
            // Bypass or an obeyed sync parks the divider at its start level
            // with the phase reloaded, so release always restarts cleanly.
            // A count above a newly written field wraps through zero.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    state_r[gi] <= ccd_pkg::CCD_ST_HOLD;
                    cnt_r[gi] <= 4'h0;
                    phase_cnt_r[gi] <= 4'h0;
                    level_r[gi] <= 1'b0;
                end else if (cfg.bypass || hold) begin
                    state_r[gi] <= ccd_pkg::CCD_ST_HOLD;
                    cnt_r[gi] <= 4'h0;
                    phase_cnt_r[gi] <= cfg.phase;
                    level_r[gi] <= cfg.start_high;
                end else if (dist_rise) begin
                    case (state_r[gi])
                        ccd_pkg::CCD_ST_HOLD: begin
                            state_r[gi] <= (phase_cnt_r[gi] == 4'h0) ?
                                           ccd_pkg::CCD_ST_RUN : ccd_pkg::CCD_ST_PHASE;
                            cnt_r[gi] <= 4'h0;
                            level_r[gi] <= cfg.start_high;
                        end
                        ccd_pkg::CCD_ST_PHASE: begin
                            phase_cnt_r[gi] <= phase_cnt_r[gi] - 4'h1;
                            if (phase_cnt_r[gi] == 4'h1) begin
                                state_r[gi] <= ccd_pkg::CCD_ST_RUN;
                            end
                        end
                        ccd_pkg::CCD_ST_RUN: begin
                            // period is low plus high spans
                            if (span_done) begin
                                cnt_r[gi] <= 4'h0;
                                level_r[gi] <= !level_r[gi];
                            end else begin
                                cnt_r[gi] <= cnt_r[gi] + 4'h1;
                            end
                        end
                        default: begin
                            state_r[gi] <= ccd_pkg::CCD_ST_HOLD;
                        end
                    endcase
                end
            end

            // Output stage: correction retimes through one more flop stage.
            // With correction off the output is one cycle earlier; the
            // span lengths are the same in both settings.
            logic dcc_r;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    dcc_r <= 1'b0;
                    out_r[gi] <= 1'b0;
                end else begin
                    dcc_r <= raw;
                    out_r[gi] <= cfg.dcc_off ? raw : dcc_r;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output pairs
    // ------------------------------------------------------------------

    // Both outputs of a pair carry the same registered level, so the
    // pair never shows skew inside this block. Direct routing is
    // already folded into the level picked for each divider.
    // each divider drives its own pair
    assign first_pair_output_a_o = out_r[0];
    assign first_pair_output_b_o = out_r[0];
    assign second_pair_output_a_o = out_r[1];
    assign second_pair_output_b_o = out_r[1];

endmodule : ccd_channel_clock_divider

`default_nettype wire

// >>> verification/ccd_monitor.sv
// Port checker for the channel clock divider, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module ccd_monitor (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Clock sources and output pairs
    input wire logic internal_oscillator_i,
    input wire logic ext_clk_i,
    input wire logic [1:0] distribution_source_select_i,
    input wire logic sync_i,
    input wire logic first_pair_output_a_o,
    input wire logic first_pair_output_b_o,
    input wire logic second_pair_output_a_o,
    input wire logic second_pair_output_b_o
);
    // -------------------------------------------------------------
    // Bus handshake
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request is answered one cycle later, for one cycle only.
    a_ack_on_request: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged after one cycle");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");
    a_ack_needs_request: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("acknowledge without a request");
    a_upper_bits_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_unmapped_reads_zero: assert property (cyc_i && stb_i && !we_i && !ack_o
        && adr_i[11:2] == 10'h000 |=> dat_o == 32'h00000000)
        else $error("unmapped word read back nonzero");
    // -------------------------------------------------------------
    // Output pairs
    // -------------------------------------------------------------
    a_first_pair_equal: assert property (
        first_pair_output_a_o == first_pair_output_b_o)
        else $error("first pair outputs differ");
    a_second_pair_equal: assert property (
        second_pair_output_a_o == second_pair_output_b_o)
        else $error("second pair outputs differ");
    a_reset_quiet: assert property (
        disable iff (1'b0) rst_i |=> !ack_o && !first_pair_output_a_o && !second_pair_output_a_o)
        else $error("outputs not low after reset edge");
    // Without source edges, sync changes or bus traffic the outputs stay put.
    sequence quiet_s;
        (!cyc_i && $stable(ext_clk_i) && $stable(internal_oscillator_i) && $stable(sync_i)
            && $stable(distribution_source_select_i)) [*8];
    endsequence
    a_hold_when_quiet: assert property (
        quiet_s |-> $stable(first_pair_output_a_o) && $stable(second_pair_output_a_o))
        else $error("output moved without a source edge");
    // Main scenarios seen.
    c_write_acked: cover property (cyc_i && stb_i && we_i && ack_o);
    c_read_acked: cover property (cyc_i && stb_i && !we_i && ack_o);
    c_first_rise: cover property ($rose(first_pair_output_a_o));
    c_second_rise: cover property ($rose(second_pair_output_a_o));
endmodule : ccd_monitor

bind ccd_channel_clock_divider ccd_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .internal_oscillator_i(internal_oscillator_i), .ext_clk_i(ext_clk_i),
    .distribution_source_select_i(distribution_source_select_i), .sync_i(sync_i),
    .first_pair_output_a_o(first_pair_output_a_o), .first_pair_output_b_o(first_pair_output_b_o),
    .second_pair_output_a_o(second_pair_output_a_o),
    .second_pair_output_b_o(second_pair_output_b_o));
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the channel clock divider.
// Assumes the design and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb;
    // -------------------------------------------------------------
    // Signals and source clocks
    // -------------------------------------------------------------
    localparam int EXT_H = 3;
    localparam int OSC_H = 5;
    localparam int LIM = 2000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic osc = 1'b0;
    logic ext = 1'b0;
    logic [1:0] src = 2'h0;
    logic sync_i = 1'b0;
    logic out0a;
    logic out0b;
    logic out1a;
    logic out1b;
    logic gen_en = 1'b1;
    logic [31:0] rd;
    logic [7:0] v;
    int ext_cnt = 0;
    int osc_cnt = 0;
    int wait_n = 0;
    int num_errors = 0;
    int checks_done = 0;
    int seed;

    ccd_channel_clock_divider dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .internal_oscillator_i(osc), .ext_clk_i(ext), .distribution_source_select_i(src),
        .sync_i(sync_i), .first_pair_output_a_o(out0a), .first_pair_output_b_o(out0b),
        .second_pair_output_a_o(out1a), .second_pair_output_b_o(out1b));

    // System clock.
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // External clock and oscillator as slow square waves of the system clock.
    always @(posedge clk_i) begin
        if (gen_en) begin
            ext_cnt <= (ext_cnt == EXT_H - 1) ? 0 : ext_cnt + 1;
            osc_cnt <= (osc_cnt == OSC_H - 1) ? 0 : osc_cnt + 1;
            if (ext_cnt == EXT_H - 1) ext <= ~ext;
            if (osc_cnt == OSC_H - 1) osc <= ~osc;
        end
    end

    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic step;
        @(posedge clk_i);
        wait_n++;
    endtask : step

    // One classic cycle; held until ack is sampled high.
    task automatic wb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'hF;
        dat_i <= {24'h000000, wd};
        wait_n = 0;
        step();
        while (ack_o !== 1'b1 && wait_n < 20) step();
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask : wb

    function automatic logic pick(input bit w);
        return w ? out1a : out0a;
    endfunction : pick

    // Times the high and low spans of the third full period seen.
    task automatic measure(input bit w, input int ph, input int pl);
        int t0;
        int hi;
        int lo;
        wait_n = 0;
        repeat (2) begin
            while (pick(w) !== 1'b0 && wait_n < LIM) step();
            while (pick(w) !== 1'b1 && wait_n < LIM) step();
            t0 = wait_n;
            while (pick(w) === 1'b1 && wait_n < LIM) step();
            hi = wait_n - t0;
            t0 = wait_n;
            while (pick(w) === 1'b0 && wait_n < LIM) step();
            lo = wait_n - t0;
        end
        if (wait_n >= LIM) begin
            num_errors++;
            end_of_test();
        end
        check("high span", ph, hi);
        check("low span", pl, lo);
    endtask : measure

    // Output must sit at one level once the settings have landed.
    task automatic hold(input bit w, input logic lvl);
        int bad;
        bad = 0;
        repeat (20) step();
        repeat (40) begin
            step();
            if (pick(w) !== lvl) bad++;
        end
        check("held level", 0, bad);
    endtask : hold

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        seed = $urandom(32'h635D);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, then the default divider behaviour.
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, (i < 3 ? 10'h190 : 10'h193) + 10'(i), 8'h00);
            check("reset value", (i == 1) ? 32'h80 : 32'h00, rd);
        end
        measure(1'b0, EXT_H, EXT_H);
        measure(1'b1, 2 * EXT_H, 2 * EXT_H);
        wb(1'b1, 10'h000, 8'h5A);
        wb(1'b0, 10'h000, 8'h00);
        check("unmapped word", 32'h00, rd);
        // Random write and read back of all six configuration registers.
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom) & ((i % 3 == 2) ? 8'h03 : 8'hFF);
            wb(1'b1, (i < 3 ? 10'h190 : 10'h193) + 10'(i), v);
            wb(1'b0, (i < 3 ? 10'h190 : 10'h193) + 10'(i), 8'h00);
            check("read back", {24'h000000, v}, rd);
        end
        // Cycle counts on both dividers, corners then random.
        for (int k = 0; k < 8; k++) begin
            v = (k == 0) ? 8'hF0 : (k == 1) ? 8'h0F : 8'($urandom);
            wb(1'b1, k[0] ? 10'h197 : 10'h191, 8'h00);
            wb(1'b1, k[0] ? 10'h198 : 10'h192, 8'h00);
            wb(1'b1, k[0] ? 10'h196 : 10'h190, v);
            measure(k[0], (v[3:0] + 1) * 2 * EXT_H, (v[7:4] + 1) * 2 * EXT_H);
        end
        // Sync hold with start level, then forced levels.
        sync_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, 10'h197, (k < 2) ? (k == 0 ? 8'h10 : 8'h00) : (k == 2 ? 8'h60 : 8'h40));
            hold(1'b1, k[0] ? 1'b0 : 1'b1);
        end
        sync_i <= 1'b0;
        wb(1'b1, 10'h196, 8'h00);
        measure(1'b1, 2 * EXT_H, 2 * EXT_H);
        // Direct routing for select codes 10b, 00b and 01b.
        wb(1'b1, 10'h190, 8'h11);
        wb(1'b1, 10'h192, 8'h02);
        for (int k = 0; k < 3; k++) begin
            src <= (k == 0) ? 2'h2 : (k == 1) ? 2'h0 : 2'h1;
            measure(1'b0, k == 0 ? OSC_H : k == 1 ? EXT_H : 4 * EXT_H,
                k == 0 ? OSC_H : k == 1 ? EXT_H : 4 * EXT_H);
        end
        // Duty correction off keeps the same spans.
        src <= 2'h0;
        wb(1'b1, 10'h192, 8'h01);
        measure(1'b0, 4 * EXT_H, 4 * EXT_H);
        // Sources stopped: outputs must settle and stay.
        gen_en <= 1'b0;
        repeat (30) step();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
